// ---- rtl/hbi_host_bus_interface.v ----
/*
 * Host bus interface of a video controller: straps, video clock pins,
 * address latch, buffer control, ready, interrupt, 16-bit claims,
 * decode enables, BIOS ROM enable and byte lanes, with AXI4-Lite regs.
 * Assumes host pins are asynchronous; video memory handshake is on clk_sys_i.
 */
// Operation
// - Load configuration straps from memory data
// - Select first video clock when bits zero
// - Strap fixes both clock pin directions
// - Second clock pin pulses or mirrors bit2
// - Third clock pin paradigm bit or bit3 when strap bit4 set
// - AT mode latches high address on ALE fall
// - Drive address and data buffer enables low
// - Direction low except during read cycles
// - Ready low until video access completes
// - Never wait-state I/O or ROM cycles
// - Interrupt only when enable bit five set
// - Interrupt high in AT, low otherwise
// - Interrupt at display end, cleared by bit4
// - Claim 16-bit transfers per bus mode
// - AT decodes I/O while enable low
// - Micro Channel decodes while enable high
// - ROM enable in C0000-C7FFF when permitted
// - AT port 46E8 write strobes ROM enable
// - High-to-low enable for 8-bit ROM pair
// - Memory decode only while memory enable high
// - Byte lanes: word, high, low, illegal
`timescale 1ns/10ps
`include "hbi_consts.vh"
module hbi_host_bus_interface (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        resetn_i,
    // Host bus pins
    input  wire        ale_i,
    input  wire [6:0]  addr_hi_i,
    input  wire [15:0] addr_lo_i,
    input  wire [7:0]  host_data_i,
    input  wire        bhe_n_i,
    input  wire        mrd_n_i,
    input  wire        mwr_n_i,
    input  wire        ior_n_i,
    input  wire        iow_n_i,
    input  wire        io_decode_enable_i,
    input  wire        memory_decode_enable_i,
    output reg         address_buffer_enable_n_o,
    output reg         low_data_buffer_enable_n_o,
    output reg         high_data_buffer_enable_n_o,
    output reg         dir_o,
    output reg         ready_o,
    output reg         memcs16_n_o,
    output reg         irq_o,
    output reg         bios_rom_enable_n_o,
    output reg         high_to_low_byte_enable_n_o,
    // Strap and video clock pins
    input  wire [15:0] display_memory_data_bus_i,
    input  wire        video_clock_b_i,
    input  wire        video_clock_c_i,
    output reg         video_clock_b_o,
    output reg         video_clock_b_oe_o,
    output reg         video_clock_c_o,
    output reg         video_clock_c_oe_o,
    output reg  [1:0]  video_clock_sel_o,
    // Internal video memory and display
    input  wire        mem_access_done_i,
    input  wire        vdisp_end_i,
    // AXI4-Lite slave
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    localparam SW = 55;

    // Pin synchronisation
    wire [SW-1:0] pin_raw;
    wire [SW-1:0] pin_s;
    assign pin_raw = {ale_i, mrd_n_i, mwr_n_i, ior_n_i, iow_n_i, bhe_n_i,
                      io_decode_enable_i, memory_decode_enable_i, addr_hi_i,
                      addr_lo_i, host_data_i, display_memory_data_bus_i};

    hbi_sync2 #(
        .WIDTH   (SW),
        .RST_VAL ({8'h7e, 47'h0})
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .d_i       (pin_raw),
        .q_o       (pin_s)
    );

    wire        s_ale   = pin_s[54];
    wire        s_mrd_n = pin_s[53];
    wire        s_mwr_n = pin_s[52];
    wire        s_ior_n = pin_s[51];
    wire        s_iow_n = pin_s[50];
    wire        s_bhe_n = pin_s[49];
    wire        s_eio   = pin_s[48];
    wire        s_memory_decode_enable  = pin_s[47];
    wire [6:0]  s_ahi   = pin_s[46:40];
    wire [15:0] s_alo   = pin_s[39:24];
    wire [7:0]  s_data  = pin_s[23:16];
    wire [15:0] s_strap = pin_s[15:0];

    // State
    reg  [15:0] strap;
    reg  [1:0]  strap_wait;
    reg         strap_done;
    reg  [4:0]  ctrl;
    reg  [7:0]  misc;
    reg  [7:0]  vre;
    reg         pend;
    reg         ale_q;
    reg  [6:0]  lat_hi;

    wire at_mode  = strap[`HBI_CNF_AT];
    wire clk_out  = ~strap[`HBI_CNF_DIR];
    wire clk_src  = strap[`HBI_CNF_CLKSRC];
    wire eight    = ctrl[`HBI_CTRL_EIGHT_BIT];

    // Strap capture after reset release and synchroniser settle
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strap      <= `HBI_STRAP_RST;
            strap_wait <= 2'h0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            strap_wait <= strap_wait + 2'h1;
            if (strap_wait == `HBI_STRAP_SETTLE) begin
                strap      <= s_strap;
                strap_done <= 1'b1;
            end
        end
    end

    // Upper address latch
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ale_q  <= 1'b0;
            lat_hi <= 7'h00;
        end else begin
            ale_q <= s_ale;
            if (at_mode && ale_q && !s_ale) begin
                lat_hi <= s_ahi;
            end
        end
    end

    // Cycle decode
    wire [6:0] addr_hi = at_mode ? lat_hi : s_ahi;
    wire       cmd     = ~s_iow_n;
    wire       mem_rd  = at_mode ? ~s_mrd_n : (cmd & s_mrd_n & ~s_ior_n);
    wire       mem_wr  = at_mode ? ~s_mwr_n : (cmd & s_mrd_n & ~s_mwr_n);
    wire       io_rd   = at_mode ? ~s_ior_n : (cmd & ~s_mrd_n & ~s_ior_n);
    wire       io_wr   = at_mode ? ~s_iow_n : (cmd & ~s_mrd_n & ~s_mwr_n);
    wire       io_ok   = at_mode ? ~s_eio : s_eio;
    wire       mem_ok  = s_memory_decode_enable & (at_mode | s_eio);
    wire [1:0] lanes   = {s_bhe_n, s_alo[0]};
    wire       legal   = (lanes == `HBI_LANE_WORD) | (lanes == `HBI_LANE_HIGH) |
                         (lanes == `HBI_LANE_LOW);
    wire       vid_hit = mem_ok & (addr_hi == `HBI_PAGE_VIDEO);
    wire       rom_hit = mem_ok & (addr_hi == `HBI_PAGE_ROM) & ~s_alo[15]
                         & ctrl[`HBI_CTRL_ROM_EN];
    wire       io_hit  = io_ok & ((s_alo[15:5] == `HBI_IO_BASE_HI) |
                         (at_mode & (s_alo == `HBI_PORT_ROM_MAP)));
    wire       mem_cyc = (mem_rd | mem_wr) & (vid_hit | (rom_hit & mem_rd));
    wire       io_cyc  = (io_rd | io_wr) & io_hit;
    wire       claim   = legal & (mem_cyc | io_cyc);
    wire       rd_cyc  = claim & (mem_rd | io_rd);
    wire       rom_rd  = claim & rom_hit & mem_rd;
    wire       vid_cyc = claim & vid_hit & (mem_rd | mem_wr);
    wire       p_misc  = legal & io_wr & io_ok & (s_alo == `HBI_PORT_MISC);
    wire       p_rom   = legal & at_mode & io_wr & io_ok & (s_alo == `HBI_PORT_ROM_MAP);
    wire       high_to_low_byte_enable     = rom_rd & eight & ctrl[`HBI_CTRL_ROM_PAIR] &
                         (lanes == `HBI_LANE_HIGH);
    wire       lane_lo = (lanes == `HBI_LANE_WORD) | (lanes == `HBI_LANE_LOW);
    wire       lane_hi = (lanes == `HBI_LANE_WORD) | (lanes == `HBI_LANE_HIGH);

    // Host bus outputs
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            address_buffer_enable_n_o   <= 1'b1;
            low_data_buffer_enable_n_o  <= 1'b1;
            high_data_buffer_enable_n_o <= 1'b1;
            dir_o                       <= 1'b0;
            ready_o                     <= 1'b1;
            memcs16_n_o                 <= 1'b1;
            bios_rom_enable_n_o         <= 1'b1;
            high_to_low_byte_enable_n_o <= 1'b1;
        end else begin
            address_buffer_enable_n_o   <= ~claim;
            low_data_buffer_enable_n_o  <= ~(claim & lane_lo & ~high_to_low_byte_enable);
            high_data_buffer_enable_n_o <= ~(claim & lane_hi & ~eight);
            dir_o                       <= rd_cyc;
            ready_o                     <= ~(vid_cyc & ~mem_access_done_i);
            memcs16_n_o                 <= ~(~eight & (at_mode ? vid_cyc :
                                             (vid_cyc | io_cyc & claim)));
            bios_rom_enable_n_o         <= ~(rom_rd | p_rom);
            high_to_low_byte_enable_n_o <= ~high_to_low_byte_enable;
        end
    end

    // Video clock pins and selection
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            video_clock_b_o    <= 1'b1;
            video_clock_b_oe_o <= 1'b0;
            video_clock_c_o    <= 1'b0;
            video_clock_c_oe_o <= 1'b0;
            video_clock_sel_o  <= 2'h0;
        end else begin
            video_clock_b_oe_o <= clk_out & strap_done;
            video_clock_c_oe_o <= clk_out & strap_done;
            video_clock_b_o    <= ctrl[`HBI_CTRL_MIRROR] ?
                                  misc[`HBI_MISC_SEL_LO] : ~p_misc;
            video_clock_c_o    <= clk_src & (ctrl[`HBI_CTRL_MIRROR] ?
                                  misc[`HBI_MISC_SEL_HI] :
                                  ctrl[`HBI_CTRL_PARADIGM]);
            video_clock_sel_o  <= clk_out ? 2'h0 :
                                  misc[`HBI_MISC_SEL_HI:`HBI_MISC_SEL_LO];
        end
    end

    // AXI4-Lite write channel
    reg  [3:0]  aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_held;
    wire        do_wr  = aw_held & w_held & ~s_axi_bvalid;
    wire        wr_vre = do_wr & (aw_addr == `HBI_OFF_VRE) & w_strb[0];
    wire        clr    = wr_vre & ~w_data[`HBI_VRE_CLR_N];

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `HBI_RESP_OKAY;
            aw_addr       <= 4'h0;
            aw_held       <= 1'b0;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            w_held        <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == `HBI_OFF_CTRL || aw_addr == `HBI_OFF_MISC ||
                                 aw_addr == `HBI_OFF_VRE || aw_addr == `HBI_OFF_STAT) ?
                                `HBI_RESP_OKAY : `HBI_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Control registers; host port writes to misc win over software
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl <= `HBI_CTRL_RST;
            misc <= `HBI_MISC_RST;
            vre  <= `HBI_VRE_RST;
        end else begin
            if (do_wr && aw_addr == `HBI_OFF_CTRL && w_strb[0]) begin
                ctrl <= w_data[`HBI_CTRL_W-1:0];
            end
            if (p_misc) begin
                misc <= s_data;
            end else if (do_wr && aw_addr == `HBI_OFF_MISC && w_strb[0]) begin
                misc <= w_data[7:0];
            end
            if (wr_vre) begin
                vre <= w_data[7:0];
            end
        end
    end

    // Vertical interrupt, set wins over clear
    wire irq_en = vre[`HBI_VRE_IRQ_EN];
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend  <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            pend  <= (vdisp_end_i & irq_en) | (pend & ~clr);
            irq_o <= at_mode ? (pend & irq_en) : ~(pend & irq_en);
        end
    end

    // AXI4-Lite read channel
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `HBI_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `HBI_RESP_OKAY;
                case (s_axi_araddr)
                    `HBI_OFF_CTRL: begin
                        s_axi_rdata <= {27'h0, ctrl};
                    end
                    `HBI_OFF_MISC: begin
                        s_axi_rdata <= {24'h0, misc};
                    end
                    `HBI_OFF_VRE: begin
                        s_axi_rdata <= {24'h0, vre};
                    end
                    `HBI_OFF_STAT: begin
                        s_axi_rdata <= {14'h0, at_mode, pend, strap};
                    end
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `HBI_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// ---- rtl/hbi_consts.vh ----
/*
 * Constants for the host bus interface: register map, field positions,
 * strap bit positions, host address decodes and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef HBI_CONSTS_VH
`define HBI_CONSTS_VH

// Register byte offsets
`define HBI_OFF_CTRL        4'h0
`define HBI_OFF_MISC        4'h4
`define HBI_OFF_VRE         4'h8
`define HBI_OFF_STAT        4'hc

// Control register fields
`define HBI_CTRL_ROM_EN     0
`define HBI_CTRL_PARADIGM   1
`define HBI_CTRL_MIRROR     2
`define HBI_CTRL_EIGHT_BIT  3
`define HBI_CTRL_ROM_PAIR   4
`define HBI_CTRL_W          5
`define HBI_CTRL_RST        5'h00

// Miscellaneous output fields
`define HBI_MISC_SEL_LO     2
`define HBI_MISC_SEL_HI     3
`define HBI_MISC_RST        8'h00

// Vertical retrace end fields
`define HBI_VRE_CLR_N       4
`define HBI_VRE_IRQ_EN      5
`define HBI_VRE_RST         8'h00

// Status register fields
`define HBI_STAT_PEND       16
`define HBI_STAT_AT         17

// Strap bit positions on the display memory data bus
`define HBI_CNF_AT          2
`define HBI_CNF_DIR         3
`define HBI_CNF_CLKSRC      4
`define HBI_STRAP_RST       16'hffff
`define HBI_STRAP_SETTLE    2'h3

// Host address decodes
`define HBI_PAGE_VIDEO      7'h05
`define HBI_PAGE_ROM        7'h06
`define HBI_IO_BASE_HI      11'h01e
`define HBI_PORT_MISC       16'h03c2
`define HBI_PORT_ROM_MAP    16'h46e8

// Byte lane codes of {bhe_n, sa0}
`define HBI_LANE_WORD       2'h0
`define HBI_LANE_HIGH       2'h1
`define HBI_LANE_LOW        2'h2

// AXI responses
`define HBI_RESP_OKAY       2'h0
`define HBI_RESP_SLVERR     2'h2

`endif

// ---- rtl/hbi_sync2.v ----
/*
 * Two flip-flop synchroniser for a vector of pin inputs.
 * Assumes each bit is independent; the reset value is a parameter.
 */
`timescale 1ns/10ps
module hbi_sync2 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire             clk_sys_i,
    input  wire             resetn_i,
    // Data
    input  wire [WIDTH-1:0] d_i,
    output reg  [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= RST_VAL;
            q_o  <= RST_VAL;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// ---- tb/hbi_host_bus_interface_monitor.sv ----
/*
 * Checker for the host bus interface top ports.
 * Assumes AT straps and host strobes held three edges before outputs move.
 */
`timescale 1ns/10ps
module hbi_monitor (
    // Clock and reset
    input wire        clk_sys_i,
    input wire        resetn_i,
    // Watched ports
    input wire [15:0] addr_lo_i,
    input wire        bhe_n_i,
    input wire        mrd_n_i,
    input wire        mwr_n_i,
    input wire        ior_n_i,
    input wire        iow_n_i,
    input wire        mem_access_done_i,
    input wire        vdisp_end_i,
    input wire        s_axi_wvalid,
    input wire        ready_o,
    input wire        dir_o,
    input wire        irq_o,
    input wire        memcs16_n_o,
    input wire        address_buffer_enable_n_o,
    input wire        low_data_buffer_enable_n_o,
    input wire        high_data_buffer_enable_n_o,
    input wire        high_to_low_byte_enable_n_o,
    input wire        video_clock_b_oe_o,
    input wire        video_clock_c_oe_o
);
    wire no_strobe = mrd_n_i & mwr_n_i & ior_n_i & iow_n_i;
    wire lane_bad  = bhe_n_i & addr_lo_i[0];
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    a_ready_wait: assert property (!ready_o |-> !$past(mem_access_done_i))
        else $error("ready low while access could complete");
    a_irq_cause: assert property ($rose(irq_o) |-> $past(vdisp_end_i, 2))
        else $error("interrupt rose without display end");
    a_irq_clear: assert property ($fell(irq_o) |-> $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
        else $error("interrupt dropped without register write");
    a_dir_read: assert property (dir_o |-> !$past(mrd_n_i, 3) || !$past(ior_n_i, 3))
        else $error("direction high outside read");
    a_abuf_cycle: assert property (!address_buffer_enable_n_o |-> !$past(no_strobe, 3))
        else $error("address buffer open without cycle");
    a_oe_pair: assert property (video_clock_b_oe_o == video_clock_c_oe_o)
        else $error("clock pin directions differ");
    a_htl_alone: assert property (!high_to_low_byte_enable_n_o
        |-> low_data_buffer_enable_n_o && high_data_buffer_enable_n_o)
        else $error("high-to-low with data buffer open");
    a_lane_illegal: assert property (!memcs16_n_o |-> !$past(lane_bad, 3))
        else $error("claim on illegal lanes");
    c_irq: cover property ($rose(irq_o));
    c_wait: cover property ($fell(ready_o));
    c_htl: cover property (!high_to_low_byte_enable_n_o);
endmodule

// ---- tb/hbi_host_model.sv ----
/*
 * Behavioural AT host bus master driving the block's host pins.
 * Assumes the caller spaces cycles; holds strobes until ready is high.
 */
`timescale 1ns/10ps
module hbi_host_model (
    // Clock and answer
    input  wire         clk_sys_i,
    input  wire         ready_i,
    // Host pins
    output logic        ale_o = 1'b0,
    output logic [6:0]  addr_hi_o = 7'h00,
    output logic [15:0] addr_lo_o = 16'h0000,
    output logic [7:0]  data_o = 8'h00,
    output logic        bhe_n_o = 1'b1,
    output logic [3:0]  strobe_n_o = 4'hf,
    output logic        aen_o = 1'b1,
    output logic        memory_decode_enable_o = 1'b1
);
    // Address, ALE pulse, then strobe k (0 mrd, 1 mwr, 2 ior, 3 iow)
    task start(input logic [1:0] k, input logic [6:0] hi, input logic [15:0] lo,
               input logic b, input logic e, input logic n, input logic [7:0] d);
        @(posedge clk_sys_i);
        ale_o <= 1'b1;
        addr_hi_o <= hi;
        addr_lo_o <= lo;
        bhe_n_o <= b;
        memory_decode_enable_o <= e;
        aen_o <= n;
        data_o <= d;
        @(posedge clk_sys_i);
        ale_o <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        strobe_n_o[k] <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
    endtask
    // Hold until ready, then release strobes; low address and data lines show inverted values
    task stop;
        @(negedge clk_sys_i);
        while (ready_i !== 1'b1) begin
            @(negedge clk_sys_i);
        end
        @(posedge clk_sys_i);
        strobe_n_o <= 4'hf;
        addr_lo_o <= ~addr_lo_o;
        data_o <= ~data_o;
        aen_o <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
    endtask
endmodule

// ---- tb/test_host_bus_interface.sv ----
/*
 * Self-checking bench: row table of host cycles, then register and
 * interrupt tests. Assumes AT straps with clock pins as outputs.
 */
`timescale 1ns/10ps
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin fails++; \
    $display("wrong value at %0t: %s", $time, m); end end
module test_host_bus_interface;
    logic clk_sys_i = 1'b0, resetn_i = 1'b0, done = 1'b0, vde = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, sel;
    logic [31:0] rdata;
    logic ale, bhe_n, aen, memory_decode_enable, abuf, dbl, dbh, dir, rdy, mcs, rom, high_to_low_byte_enable, irq;
    logic vb, vboe, vc, vcoe;
    logic [6:0] hi;
    logic [15:0] lo;
    logic [7:0] hd;
    logic [3:0] stb;
    int fails = 0, cmp_count = 0;
    typedef struct {logic [1:0] k; logic [6:0] hi; logic [15:0] lo;
        logic b, e, n; logic [7:0] x, m;} hbi_row_t;
    hbi_row_t rows [10] = '{
        '{0, 7'h05, 16'h0000, 1, 1, 0, 8'h33, 8'hff}, '{1, 7'h05, 16'h0001, 0, 1, 0, 8'h43, 8'hfb},
        '{1, 7'h05, 16'h0000, 1, 1, 0, 8'h23, 8'hfb}, '{0, 7'h05, 16'h0001, 1, 1, 0, 8'hef, 8'hff},
        '{0, 7'h05, 16'h0000, 0, 0, 0, 8'hef, 8'hff}, '{0, 7'h06, 16'h0000, 0, 1, 0, 8'h19, 8'h1b},
        '{3, 7'h00, 16'h03c2, 1, 1, 0, 8'h0a, 8'h1b}, '{3, 7'h00, 16'h46e8, 1, 1, 0, 8'h09, 8'h1b},
        '{2, 7'h00, 16'h03c4, 1, 1, 0, 8'h1b, 8'h5b}, '{2, 7'h00, 16'h03c4, 1, 1, 1, 8'h0b, 8'h1b}};
    wire [7:0] got = {abuf, dbl, dbh, dir, rdy, mcs, rom, vb};
    always #5 clk_sys_i = ~clk_sys_i;
    hbi_host_model host (.clk_sys_i(clk_sys_i), .ready_i(rdy), .ale_o(ale), .addr_hi_o(hi),
        .addr_lo_o(lo), .data_o(hd), .bhe_n_o(bhe_n), .strobe_n_o(stb), .aen_o(aen), .memory_decode_enable_o(memory_decode_enable));
    hbi_host_bus_interface DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ale_i(ale),
        .addr_hi_i(hi), .addr_lo_i(lo), .host_data_i(hd), .bhe_n_i(bhe_n), .mrd_n_i(stb[0]),
        .mwr_n_i(stb[1]), .ior_n_i(stb[2]), .iow_n_i(stb[3]), .io_decode_enable_i(aen),
        .memory_decode_enable_i(memory_decode_enable), .address_buffer_enable_n_o(abuf),
        .low_data_buffer_enable_n_o(dbl), .high_data_buffer_enable_n_o(dbh), .dir_o(dir),
        .ready_o(rdy), .memcs16_n_o(mcs), .irq_o(irq), .bios_rom_enable_n_o(rom),
        .high_to_low_byte_enable_n_o(high_to_low_byte_enable), .display_memory_data_bus_i(16'hfff7),
        .video_clock_b_i(1'b1), .video_clock_c_i(1'b0), .video_clock_b_o(vb),
        .video_clock_b_oe_o(vboe), .video_clock_c_o(vc), .video_clock_c_oe_o(vcoe),
        .video_clock_sel_o(sel), .mem_access_done_i(done), .vdisp_end_i(vde),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task finish_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // AXI write: hold each channel until taken, bready until bvalid
    task axw(input logic [3:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge clk_sys_i);
        {awaddr, awvalid, wdata, wvalid, bready} <= {a, 1'b1, d, 1'b1, 1'b1};
        do begin
            @(negedge clk_sys_i);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid & bready;
            @(posedge clk_sys_i);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end while (!tb);
        `CHK(bresp, 2'h0, "write response")
        repeat (3) @(posedge clk_sys_i);
    endtask
    task axr(input logic [3:0] a);
        logic ta, tr;
        @(posedge clk_sys_i);
        {araddr, arvalid, rready} <= {a, 1'b1, 1'b1};
        do begin
            @(negedge clk_sys_i);
            ta = arvalid & arready;
            tr = rvalid & rready;
            rd = rdata;
            @(posedge clk_sys_i);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end while (!tr);
        `CHK(rresp, 2'h0, "read response")
    endtask
    task pulse_vde;
        @(posedge clk_sys_i);
        vde <= 1'b1;
        @(posedge clk_sys_i);
        vde <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask
    initial begin
        #500000;
        fails++;
        finish_test;
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        axr(4'hc);
        `CHK(rd, 32'h0002fff7, "straps and mode")
        `CHK({vboe, vcoe}, 2'b11, "clock pins driven")
        `CHK(sel, 2'h0, "first video clock")
        axr(4'h0);
        `CHK(rd, 32'h0, "control reset")
        $display("reset test done");
        axw(4'h0, 32'h1);
        foreach (rows[i]) begin
            host.start(rows[i].k, rows[i].hi, rows[i].lo, rows[i].b, rows[i].e, rows[i].n, 8'h00);
            `CHK(got & rows[i].m, rows[i].x & rows[i].m, "host cycle row")
            @(posedge clk_sys_i);
            done <= 1'b1;
            host.stop;
            done <= 1'b0;
        end
        $display("row test done");
        axw(4'h0, 32'h2);
        `CHK(vc, 1'b1, "paradigm bit out")
        axw(4'h0, 32'h0);
        `CHK(vc, 1'b0, "paradigm bit clear")
        host.start(0, 7'h06, 16'h0000, 0, 1, 0, 8'h00);
        `CHK(rom, 1'b1, "rom disabled")
        host.stop;
        axw(4'h0, 32'h19);
        host.start(0, 7'h06, 16'h0001, 0, 1, 0, 8'h00);
        `CHK(high_to_low_byte_enable, 1'b0, "high-to-low open")
        host.stop;
        $display("clock and rom test done");
        axw(4'h8, 32'h30);
        pulse_vde;
        `CHK(irq, 1'b1, "interrupt raised")
        repeat (20) @(posedge clk_sys_i);
        `CHK(irq, 1'b1, "interrupt held")
        axw(4'h8, 32'h20);
        `CHK(irq, 1'b0, "interrupt cleared")
        axw(4'h8, 32'h10);
        pulse_vde;
        `CHK(irq, 1'b0, "interrupt disabled")
        $display("interrupt test done");
        finish_test;
    end
endmodule
bind hbi_host_bus_interface hbi_monitor u_mon (.*);
